// ===== fcr_defs.vh
`ifndef FCR_DEFS_VH
`define FCR_DEFS_VH

// register indexes; byte address is four times the index
`define FCR_IDX_CMD_INDEX     6'h02
`define FCR_IDX_FACTORY_RSV   6'h03
`define FCR_IDX_FLASH_CONFIG  6'h04
`define FCR_IDX_ERR_IRQ_CFG   6'h05
`define FCR_IDX_FLASH_STATUS  6'h06
`define FCR_IDX_ERR_STATUS    6'h07
`define FCR_IDX_ECC_ADDR_HI   6'h08
`define FCR_IDX_ECC_ADDR_LO   6'h09
`define FCR_IDX_IRQ_STATUS    6'h0a
`define FCR_IDX_IRQ_MASK      6'h0b

// bus address field holding the index
`define FCR_ADR_MSB           7
`define FCR_ADR_LSB           2

// command index register layout
`define FCR_CMD_INDEX_MSB     2
`define FCR_CMD_INDEX_RST     3'h0

// flash configuration register bit positions
`define FCR_CFG_CMD_DONE_IE   7
`define FCR_CFG_SUPPRESS_SF   4
`define FCR_CFG_FORCE_DF      1
`define FCR_CFG_FORCE_SF      0

// error irq configuration and error status bit positions
`define FCR_ERR_DF            1
`define FCR_ERR_SF            0

// flash status bit position
`define FCR_STAT_CMD_DONE     7

// interrupt status and mask layout
`define FCR_IRQ_W             3
`define FCR_IRQ_SF            0
`define FCR_IRQ_DF            1
`define FCR_IRQ_CMD           2
`define FCR_IRQ_RST           3'h0

// widths and reset values
`define FCR_REG_RST           8'h00
`define FCR_ECC_ADDR_RST      16'h0000
`define FCR_DAT_ZERO          32'h00000000

`endif

// ===== fcr_evt_irq.v
`timescale 1ns/1ps
`include "fcr_defs.vh"

module fcr_evt_irq (
	input  wire                   clock,
	input  wire                   reset,
	input  wire [`FCR_IRQ_W-1:0]  evt,
	input  wire                   rd_clr,
	input  wire                   mask_we,
	input  wire [`FCR_IRQ_W-1:0]  mask_wdata,
	output reg  [`FCR_IRQ_W-1:0]  status_r,
	output reg  [`FCR_IRQ_W-1:0]  mask_r,
	output wire                   irq
);

	reg [`FCR_IRQ_W-1:0] status_nxt;

	// a new event in the clearing cycle survives: set wins over clear
	always @*
	begin
		status_nxt = status_r;
		if (rd_clr)
			status_nxt = {`FCR_IRQ_W{1'b0}};
		status_nxt = status_nxt | evt;
	end

	// sticky status and mask storage
	always @(posedge clock)
	begin
		if (reset)
		begin
			status_r <= `FCR_IRQ_RST;
			mask_r   <= `FCR_IRQ_RST;
		end
		else
		begin
			status_r <= status_nxt;
			if (mask_we)
				mask_r <= mask_wdata;
		end
	end

	// level output while any unmasked status bit is set
	assign irq = |(status_r & mask_r);

endmodule // fcr_evt_irq

// ===== fcr_flash_ctrl_regs.v
// Summary of operation
// - index field selects which command array word software accesses next
// - index register: low three bits read/write, others read zero, reset zero
// - factory test register reads all zero and discards writes
// - config register has read/write bits 7, 4, 1, 0; others read zero
// - completion interrupt requested while enable and command complete flag set; the shared irq line takes the finish event through mask bit 2 instead
// - suppress bit clear: every single fault read is recorded in error status
// - suppress bit set: real single faults set no flag and no interrupt
// - force double set: every array read sets double flag; irq needs enable (the shared irq line needs mask bit 1 instead)
// - force double clear: double flag only on a real double fault
// - force double stays set until software writes it to zero
// - force single set: every array read sets single flag; irq needs enable (the shared irq line needs mask bit 0 instead)
// - force single clear: single flag only on a real single fault
// - force single stays set until software writes it to zero
// - forced single read leaves capture unchanged unless a real double fault, or a real single fault with suppress and force double clear
// - forcing applies to processor array reads only
// - complete flag reads one when idle; writing one launches, zero until done
// - separate enables gate double and single fault interrupt requests; the shared irq line uses mask bits 1 and 0 instead
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "fcr_defs.vh"

module fcr_flash_ctrl_regs (
	input  wire        clock,
	input  wire        reset,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        cpu_array_rd,
	input  wire        ecc_single_err,
	input  wire        ecc_double_err,
	input  wire [15:0] ecc_fault_addr,
	input  wire        cmd_finished,
	output wire [2:0]  command_word_index,
	output reg         cmd_launch,
	output wire        cmd_done_irq,
	output wire        single_fault_irq,
	output wire        double_fault_irq,
	output wire        irq
);

	// bus access decode
	wire        req;
	wire        wr_take;
	wire        rd_take;
	wire [5:0]  reg_idx;
	wire [7:0]  wdat;

	// per-register write strobes and interrupt summary inputs
	wire        idx_we;
	wire        cfg_we;
	wire        err_cfg_we;
	wire        stat_we;
	wire        err_clr_we;
	wire        mask_we;
	wire        irq_rd_clr;
	wire [`FCR_IRQ_W-1:0] irq_evt;

	// register storage
	reg  [2:0]  cmd_index_r;
	reg         cmd_done_ie_r;
	reg         suppress_sf_r;
	reg         force_df_r;
	reg         force_sf_r;
	reg         df_irq_en_r;
	reg         sf_irq_en_r;
	reg         cmd_complete_flag_r;
	reg         double_fault_flag_r;
	reg         single_fault_flag_r;
	reg  [15:0] ecc_addr_r;

	// event and flag next values
	reg         cmd_complete_nxt;
	reg         df_flag_nxt;
	reg         sf_flag_nxt;
	reg  [7:0]  rd_mux;
	wire        sf_event;
	wire        df_event;
	wire        cmd_event;
	wire        capture_en;
	wire        launch_req;
	wire [`FCR_IRQ_W-1:0] irq_status;
	wire [`FCR_IRQ_W-1:0] irq_mask;

	// match of a register write to an index with lane 0 enabled
	function wr_hit;
		input [5:0] idx;
		input [5:0] target;
		input       take;
		input       lane0;
		begin
			wr_hit = take & lane0 & (idx == target);
		end
	endfunction

	assign req     = wb_cyc_i & wb_stb_i;
	assign reg_idx = wb_adr_i[`FCR_ADR_MSB:`FCR_ADR_LSB];
	assign wdat    = wb_dat_i[7:0];
	// writes act at the edge where the master sees ack high
	assign wr_take = req & wb_we_i & wb_ack_o;
	// reads latch data, and clear read-clear bits, as ack rises
	assign rd_take = req & ~wb_we_i & ~wb_ack_o;

	// one write strobe per writable register, byte lane 0 only
	assign idx_we     = wr_hit(reg_idx, `FCR_IDX_CMD_INDEX, wr_take,
		wb_sel_i[0]);
	assign cfg_we     = wr_hit(reg_idx, `FCR_IDX_FLASH_CONFIG, wr_take,
		wb_sel_i[0]);
	assign err_cfg_we = wr_hit(reg_idx, `FCR_IDX_ERR_IRQ_CFG, wr_take,
		wb_sel_i[0]);
	assign stat_we    = wr_hit(reg_idx, `FCR_IDX_FLASH_STATUS, wr_take,
		wb_sel_i[0]);
	assign err_clr_we = wr_hit(reg_idx, `FCR_IDX_ERR_STATUS, wr_take,
		wb_sel_i[0]);
	assign mask_we    = wr_hit(reg_idx, `FCR_IDX_IRQ_MASK, wr_take,
		wb_sel_i[0]);

	// ack one cycle after the request, dropped the cycle after,
	// so a request held high is answered only every other cycle
	always @(posedge clock)
	begin
		if (reset)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req & ~wb_ack_o;
	end

	// index storage; only software changes it
	always @(posedge clock)
	begin
		if (reset)
			cmd_index_r <= `FCR_CMD_INDEX_RST;
		else if (idx_we)
			cmd_index_r <= wdat[`FCR_CMD_INDEX_MSB:0];
	end

	// configuration storage; array reads never touch the force bits
	always @(posedge clock)
	begin
		if (reset)
		begin
			cmd_done_ie_r <= 1'b0;
			suppress_sf_r <= 1'b0;
			force_df_r    <= 1'b0;
			force_sf_r    <= 1'b0;
		end
		else if (cfg_we)
		begin
			cmd_done_ie_r <= wdat[`FCR_CFG_CMD_DONE_IE];
			suppress_sf_r <= wdat[`FCR_CFG_SUPPRESS_SF];
			force_df_r    <= wdat[`FCR_CFG_FORCE_DF];
			force_sf_r    <= wdat[`FCR_CFG_FORCE_SF];
		end
	end

	// separate fault interrupt enables
	always @(posedge clock)
	begin
		if (reset)
		begin
			df_irq_en_r <= 1'b0;
			sf_irq_en_r <= 1'b0;
		end
		else if (err_cfg_we)
		begin
			df_irq_en_r <= wdat[`FCR_ERR_DF];
			sf_irq_en_r <= wdat[`FCR_ERR_SF];
		end
	end

	// the index steers the outside command array word select
	assign command_word_index = cmd_index_r;

	// fault events, qualified by a processor array read
	assign df_event = cpu_array_rd &
		(ecc_double_err | force_df_r);
	// forcing still sets the flag even when reporting is suppressed
	assign sf_event = cpu_array_rd & (force_sf_r |
		(ecc_single_err & ~suppress_sf_r));

	// capture only on real faults, so forced reads keep old contents;
	// while double forcing, only a real double fault may overwrite it
	assign capture_en = cpu_array_rd & (ecc_double_err |
		(ecc_single_err & ~suppress_sf_r & ~force_df_r));

	// launch only from idle; a write while busy is ignored
	assign launch_req = stat_we & wdat[`FCR_STAT_CMD_DONE] &
		cmd_complete_flag_r;

	// completion event: a running command finishes
	assign cmd_event = cmd_finished & ~cmd_complete_flag_r;

	// summary events and the clear-on-read strobe for the shared line
	assign irq_evt    = {cmd_event, df_event, sf_event};
	assign irq_rd_clr = rd_take & (reg_idx == `FCR_IDX_IRQ_STATUS);

	// complete flag next value; launch and finish never coincide
	always @*
	begin
		cmd_complete_nxt = cmd_complete_flag_r;
		if (launch_req)
			cmd_complete_nxt = 1'b0;
		if (cmd_event)
			cmd_complete_nxt = 1'b1;
	end

	// double flag next value; a hardware set wins over a software clear
	always @*
	begin
		df_flag_nxt = double_fault_flag_r;
		if (err_clr_we & wdat[`FCR_ERR_DF])
			df_flag_nxt = 1'b0;
		if (df_event)
			df_flag_nxt = 1'b1;
	end

	// single flag next value; same priority as the double flag
	always @*
	begin
		sf_flag_nxt = single_fault_flag_r;
		if (err_clr_we & wdat[`FCR_ERR_SF])
			sf_flag_nxt = 1'b0;
		if (sf_event)
			sf_flag_nxt = 1'b1;
	end

	// complete flag is one after reset so software sees an idle unit
	always @(posedge clock)
	begin
		if (reset)
			cmd_complete_flag_r <= 1'b1;
		else
			cmd_complete_flag_r <= cmd_complete_nxt;
	end

	// double fault flag
	always @(posedge clock)
	begin
		if (reset)
			double_fault_flag_r <= 1'b0;
		else
			double_fault_flag_r <= df_flag_nxt;
	end

	// single fault flag
	always @(posedge clock)
	begin
		if (reset)
			single_fault_flag_r <= 1'b0;
		else
			single_fault_flag_r <= sf_flag_nxt;
	end

	// address of the last captured real fault; a real single fault is not captured under suppress or double forcing
	always @(posedge clock)
	begin
		if (reset)
			ecc_addr_r <= `FCR_ECC_ADDR_RST;
		else if (capture_en)
			ecc_addr_r <= ecc_fault_addr;
	end

	// launch pulse for the sequencer, one cycle after the launching write
	always @(posedge clock)
	begin
		if (reset)
			cmd_launch <= 1'b0;
		else
			cmd_launch <= launch_req;
	end

	// completion request follows the idle flag while enabled
	assign cmd_done_irq     = cmd_done_ie_r & cmd_complete_flag_r;

	// per-source request levels drop as soon as flag or enable clears
	assign double_fault_irq = df_irq_en_r & double_fault_flag_r;
	assign single_fault_irq = sf_irq_en_r & single_fault_flag_r;

	// sticky event summary for the shared interrupt line
	fcr_evt_irq u_evt_irq (
		.clock      (clock),
		.reset      (reset),
		.evt        (irq_evt),
		.rd_clr     (irq_rd_clr),
		.mask_we    (mask_we),
		.mask_wdata (wdat[`FCR_IRQ_W-1:0]),
		.status_r   (irq_status),
		.mask_r     (irq_mask),
		.irq        (irq)
	);

	// read multiplexer; unmapped and reserved indexes read zero
	always @*
	begin
		rd_mux = `FCR_REG_RST;
		case (reg_idx)
			`FCR_IDX_CMD_INDEX:
				rd_mux[`FCR_CMD_INDEX_MSB:0] = cmd_index_r;
			`FCR_IDX_FACTORY_RSV:
				rd_mux = `FCR_REG_RST;
			`FCR_IDX_FLASH_CONFIG:
			begin
				rd_mux[`FCR_CFG_CMD_DONE_IE] = cmd_done_ie_r;
				rd_mux[`FCR_CFG_SUPPRESS_SF] = suppress_sf_r;
				rd_mux[`FCR_CFG_FORCE_DF]    = force_df_r;
				rd_mux[`FCR_CFG_FORCE_SF]    = force_sf_r;
			end
			`FCR_IDX_ERR_IRQ_CFG:
			begin
				rd_mux[`FCR_ERR_DF] = df_irq_en_r;
				rd_mux[`FCR_ERR_SF] = sf_irq_en_r;
			end
			`FCR_IDX_FLASH_STATUS:
				rd_mux[`FCR_STAT_CMD_DONE] = cmd_complete_flag_r;
			`FCR_IDX_ERR_STATUS:
			begin
				rd_mux[`FCR_ERR_DF] = double_fault_flag_r;
				rd_mux[`FCR_ERR_SF] = single_fault_flag_r;
			end
			`FCR_IDX_ECC_ADDR_HI:
				rd_mux = ecc_addr_r[15:8];
			`FCR_IDX_ECC_ADDR_LO:
				rd_mux = ecc_addr_r[7:0];
			`FCR_IDX_IRQ_STATUS:
				rd_mux[`FCR_IRQ_W-1:0] = irq_status;
			`FCR_IDX_IRQ_MASK:
				rd_mux[`FCR_IRQ_W-1:0] = irq_mask;
			default:
				rd_mux = `FCR_REG_RST;
		endcase
	end

	// read data is latched as ack rises and held through the ack cycle;
	// upper bytes stay zero since every register is eight bits wide
	always @(posedge clock)
	begin
		if (reset)
			wb_dat_o <= `FCR_DAT_ZERO;
		else if (rd_take)
			wb_dat_o <= {24'h000000, rd_mux};
	end

endmodule // fcr_flash_ctrl_regs

// ===== fcr_regs_monitor.sv
`timescale 1ns/1ps
module fcr_regs_monitor (
	input wire        clock,
	input wire        reset,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        cpu_array_rd,
	input wire        cmd_finished,
	input wire [2:0]  command_word_index,
	input wire        cmd_launch,
	input wire        cmd_done_irq,
	input wire        single_fault_irq,
	input wire        double_fault_irq
);
	// new request, its register index, and a write being acknowledged
	wire       rq = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire [5:0] ix = wb_adr_i[7:2];
	wire       wr = wb_ack_o & wb_we_i;
	wire       rd = rq & !wb_we_i;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	property p_ack; rq |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse");
	property p_idx; rd && ix == 6'h02 |=> wb_dat_o[31:3] == 0; endproperty
	a_idx: assert property (p_idx) else $error("index upper bits set");
	property p_rsv; rd && ix == 6'h03 |=> wb_dat_o == 0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved reg not zero");
	property p_cfg; rd && ix == 6'h04 |=> (wb_dat_o & 32'hffffff6c) == 0;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config spare bits set");
	// the index only moves on an acknowledged write to its own register
	property p_cwi; !$stable(command_word_index) |-> $past(wr && ix == 6'h02);
	endproperty
	a_cwi: assert property (p_cwi) else $error("index changed alone");
	property p_launch;
		cmd_launch |-> $past(wr && ix == 6'h06 && wb_dat_i[7]) ##1 !cmd_launch;
	endproperty
	a_launch: assert property (p_launch) else $error("bad launch pulse");
	property p_sf; $rose(single_fault_irq) |-> $past(cpu_array_rd || wr);
	endproperty
	a_sf: assert property (p_sf) else $error("single irq without cause");
	property p_df; $rose(double_fault_irq) |-> $past(cpu_array_rd || wr);
	endproperty
	a_df: assert property (p_df) else $error("double irq without cause");
	// flags and enables only drop by software writes
	property p_fall;
		$fell(single_fault_irq) || $fell(double_fault_irq) |-> $past(wr);
	endproperty
	a_fall: assert property (p_fall) else $error("fault irq fell alone");
	property p_cd; $rose(cmd_done_irq) |-> $past(cmd_finished || wr); endproperty
	a_cd: assert property (p_cd) else $error("done irq without cause");

	c_launch: cover property (wr && ix == 6'h06);
	c_df: cover property (cpu_array_rd ##1 double_fault_irq);
	c_cd: cover property (cmd_finished ##1 cmd_done_irq);
endmodule // fcr_regs_monitor

bind fcr_flash_ctrl_regs fcr_regs_monitor u_mon (.clock(clock), .reset(reset),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .cpu_array_rd(cpu_array_rd),
	.cmd_finished(cmd_finished), .command_word_index(command_word_index),
	.cmd_launch(cmd_launch), .cmd_done_irq(cmd_done_irq),
	.single_fault_irq(single_fault_irq), .double_fault_irq(double_fault_irq));

// ===== tb_fcr_flash_ctrl_regs.sv
`timescale 1ns/1ps
module tb_fcr_flash_ctrl_regs;
	logic        clock = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic        cpu_array_rd = 0, ecc_single_err = 0, ecc_double_err = 0;
	logic        cmd_finished = 0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [15:0] ecc_fault_addr = 16'h0000;
	logic [31:0] wb_dat_i = 32'h0, q, v, s = 32'h31;
	wire  [31:0] wb_dat_o;
	wire  [2:0]  command_word_index;
	wire         wb_ack_o, cmd_launch, cmd_done_irq, irq;
	wire         single_fault_irq, double_fault_irq;
	int          err_count = 0, checks = 0, n;

	fcr_flash_ctrl_regs u_dut (.clock(clock), .reset(reset),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_array_rd(cpu_array_rd),
		.ecc_single_err(ecc_single_err), .ecc_double_err(ecc_double_err),
		.ecc_fault_addr(ecc_fault_addr), .cmd_finished(cmd_finished),
		.command_word_index(command_word_index), .cmd_launch(cmd_launch),
		.cmd_done_irq(cmd_done_irq), .single_fault_irq(single_fault_irq),
		.double_fault_irq(double_fault_irq), .irq(irq));

	// 50 MHz clock
	always #10 clock = ~clock;

	// xorshift keeps the run repeatable
	function automatic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input [31:0] seen, input [31:0] exp, input string nm);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one classic cycle; values read at an edge are those before it
	task automatic wb(input [5:0] i, input [7:0] d, input w);
		wb_adr_i <= {i, 2'b00};
		wb_dat_i <= {24'h0, d};
		wb_we_i <= w;
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 9);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge clock);
		if (n >= 9)
		begin
			err_count++;
			print_verdict();
		end
	endtask

	task automatic rc(input [5:0] i, input [31:0] e);
		wb(i, 8'h00, 0);
		chk(q, e, $sformatf("reg %0d", i));
	endtask

	// one processor array read with optional real faults
	task automatic arr(input se, input de, input [15:0] a);
		@(posedge clock);
		cpu_array_rd <= 1;
		ecc_single_err <= se;
		ecc_double_err <= de;
		ecc_fault_addr <= a;
		@(posedge clock);
		cpu_array_rd <= 0;
		ecc_single_err <= 0;
		ecc_double_err <= 0;
		@(posedge clock);
	endtask

	initial
	begin
		repeat (6) @(posedge clock);
		reset <= 0;
		@(posedge clock);
		rc(6'h02, 0);
		rc(6'h04, 0);
		rc(6'h06, 32'h80);
		// random writes across the three registers
		repeat (8)
		begin
			v = xs();
			wb(6'h02, v[7:0], 1);
			rc(6'h02, v & 7);
			chk(command_word_index, v & 7, "index out");
			wb(6'h03, v[15:8], 1);
			rc(6'h03, 0);
			wb(6'h04, v[23:16], 1);
			rc(6'h04, v[23:16] & 8'h93);
		end
		// a real single fault is recorded and captured
		wb(6'h04, 8'h00, 1);
		wb(6'h05, 8'h03, 1);
		wb(6'h0b, 8'h07, 1);
		arr(1, 0, 16'h1234);
		chk(single_fault_irq, 1, "sf irq");
		rc(6'h07, 1);
		rc(6'h08, 8'h12);
		rc(6'h0a, 1);
		wb(6'h07, 8'h03, 1);
		chk(single_fault_irq, 0, "sf irq clr");
		// forced faults set both flags yet keep the capture
		wb(6'h04, 8'h03, 1);
		arr(0, 0, 16'hbeef);
		chk(double_fault_irq, 1, "df irq");
		chk(irq, 1, "irq");
		rc(6'h07, 3);
		rc(6'h09, 8'h34);
		rc(6'h04, 3);
		rc(6'h0a, 3);
		rc(6'h0a, 0);
		chk(irq, 0, "irq clr");
		// a real single fault under double forcing must not capture
		wb(6'h04, 8'h02, 1);
		arr(1, 0, 16'h4242);
		rc(6'h09, 8'h34);
		wb(6'h04, 8'h03, 1);
		wb(6'h07, 8'h03, 1);
		// flags still set while both enables are off
		wb(6'h05, 8'h00, 1);
		arr(0, 0, 16'h0000);
		chk(double_fault_irq | single_fault_irq, 0, "irq off");
		rc(6'h07, 3);
		wb(6'h07, 8'h03, 1);
		wb(6'h05, 8'h03, 1);
		rc(6'h0a, 3);
		// suppression hides a real single fault
		wb(6'h04, 8'h10, 1);
		arr(1, 0, 16'h5555);
		chk(single_fault_irq, 0, "sf suppressed");
		rc(6'h07, 0);
		// no forcing: only real faults count, masked from irq
		wb(6'h04, 8'h00, 1);
		arr(0, 0, 16'h0000);
		rc(6'h07, 0);
		wb(6'h0b, 8'h00, 1);
		arr(0, 1, 16'h0000);
		chk(irq, 0, "irq masked");
		rc(6'h07, 2);
		rc(6'h0a, 2);
		// launch a command and finish it
		wb(6'h04, 8'h80, 1);
		chk(cmd_done_irq, 1, "done irq");
		wb(6'h06, 8'h80, 1);
		chk(cmd_launch, 1, "launch");
		rc(6'h06, 0);
		chk(cmd_done_irq, 0, "done irq busy");
		@(posedge clock);
		cmd_finished <= 1;
		@(posedge clock);
		cmd_finished <= 0;
		@(posedge clock);
		chk(cmd_done_irq, 1, "done irq end");
		rc(6'h06, 32'h80);
		rc(6'h30, 0);
		print_verdict();
	end
endmodule // tb_fcr_flash_ctrl_regs
